// *** bench/aco_alu_core_bench.sv ***
// self-checking bench for the four-phase add/and execution core
// assumes the bench plays data memory and the fetch side on the core's ports
`timescale 1ns/1ns
module aco_alu_core_bench;
    import aco_pkg::*;
    // ------------------------------------------------------------
    // stimulus, observation and expected state
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] instr = 16'h0000;
    logic instr_valid = 1'b0;
    logic [BANK_W-1:0] bank_select_register = 4'h0;
    logic [7:0] mem_rd_data = 8'h00;
    logic instr_ready, instr_unknown, instr_done, mem_rd_en, mem_wr_en;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wr_data, wreg, status;
    logic [7:0] exp_w = 8'h00;       // working register as the bench predicts it
    logic [7:0] exp_st = 8'h00;      // flags as the bench predicts them
    int error_cnt = 0;
    int cmp_count = 0;
    always #2 mclk = ~mclk;          // 4 ns period
    aco_alu_core DUT (.mclk(mclk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
        .bank_select_register(bank_select_register), .mem_rd_data(mem_rd_data),
        .instr_ready(instr_ready), .instr_unknown(instr_unknown), .instr_done(instr_done),
        .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_addr(mem_addr),
        .mem_wr_data(mem_wr_data), .wreg(wreg), .status(status));
    // ------------------------------------------------------------
    // comparison and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // one instruction, predicted and walked phase by phase
    // ------------------------------------------------------------
    task automatic run(input aco_op_t op, input logic d, input logic a, input logic [7:0] f,
        input logic [3:0] b, input logic [7:0] v);
        logic [15:0] w;
        logic [11:0] ea;
        logic [8:0] s;
        logic [7:0] r;
        logic cin, hc, vf, isadd, wr;
        cin = (op == OP_ADDC) ? exp_st[ST_C] : 1'b0;
        isadd = (op == OP_ADDC) || (op == OP_ADD);
        case (op)
            OP_ADDC: w = {OPC_ADD_CARRY, d, a, f};
            OP_ADD: w = {OPC_ADD_FILE, d, a, f};
            OP_ANDF: w = {OPC_AND_FILE, d, a, f};
            default: w = {OPC_AND_LIT, v};
        endcase
        ea = a ? {b, f} : {(f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, f};
        s = {1'b0, exp_w} + {1'b0, v} + {8'h00, cin};
        hc = ({1'b0, exp_w[3:0]} + {1'b0, v[3:0]} + {4'h0, cin}) > 5'h0f;
        vf = (exp_w[7] == v[7]) && (s[7] != exp_w[7]);
        r = isadd ? s[7:0] : (exp_w & v);
        wr = d && (op != OP_ANDL);
        // and forms leave carry, digit carry and overflow alone
        if (isadd) begin
            exp_st[ST_C] = s[8];
            exp_st[ST_DCY] = hc;
            exp_st[ST_OVF] = vf;
        end
        exp_st[ST_Z] = (r == 8'h00);
        exp_st[ST_N] = r[7];
        if (!wr) begin
            exp_w = r;
        end
        @(posedge mclk);
        instr <= w;
        instr_valid <= 1'b1;
        bank_select_register <= b;
        mem_rd_data <= v;
        // a known word on offer must not be flagged as refused
        #1;
        chk(instr_unknown, 16'h0);
        // taking edge; bank is scrambled so a late sample shows up
        @(posedge mclk);
        instr_valid <= 1'b0;
        bank_select_register <= ~b;
        #1;
        chk(instr_ready, 16'h0);
        chk(mem_rd_en, op != OP_ANDL);
        if (op != OP_ANDL && a) begin
            chk(mem_addr, ea);
        end else if (op != OP_ANDL) begin
            chk(mem_addr, ea);
        end
        // read data released once the read phase is over
        @(posedge mclk);
        mem_rd_data <= ~v;
        #1;
        chk(instr_done, 16'h0);
        @(posedge mclk);
        #1;
        chk(instr_done, 16'h1);
        chk(mem_wr_en, wr);
        if (wr) begin
            chk(mem_wr_data, r);
        end
        @(posedge mclk);
        #1;
        chk(wreg, exp_w);
        chk(status, exp_st);
        chk(instr_ready, 16'h1);
    endtask : run
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        #1;
        exp_w = WREG_RST;
        exp_st = STATUS_RST;
        chk(wreg, WREG_RST);
        chk(status, STATUS_RST);
        chk(instr_ready, 16'h1);
        chk(mem_wr_en, 16'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_add;
        run(OP_ADD, 1'b0, 1'b0, 8'h10, 4'h3, 8'h17);
        run(OP_ADD, 1'b0, 1'b0, 8'hc2, 4'h3, 8'hc2);
        run(OP_ADD, 1'b1, 1'b1, 8'h33, 4'h5, 8'h80);
        $display("add test done");
    endtask : t_add
    task automatic t_addc;
        run(OP_ADDC, 1'b0, 1'b1, 8'h02, 4'ha, 8'h26);
        run(OP_ANDL, 1'b0, 1'b0, 8'h00, 4'h0, 8'hff);
        run(OP_ADDC, 1'b1, 1'b0, 8'h7f, 4'h6, 8'h0f);
        $display("add with carry test done");
    endtask : t_addc
    task automatic t_and;
        run(OP_ADD, 1'b0, 1'b0, 8'h80, 4'h1, 8'ha3);
        run(OP_ANDL, 1'b1, 1'b1, 8'h00, 4'h0, 8'h5f);
        run(OP_ANDF, 1'b1, 1'b1, 8'h44, 4'h3, 8'h81);
        run(OP_ANDF, 1'b0, 1'b0, 8'h00, 4'h9, 8'hfc);
        $display("and test done");
    endtask : t_and
    task automatic t_refuse;
        @(posedge mclk);
        instr <= 16'hffff;
        instr_valid <= 1'b1;
        @(posedge mclk);
        #1;
        chk(instr_unknown, 16'h1);
        chk(instr_ready, 16'h1);
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk(instr_ready, 16'h1);
        chk(mem_rd_en, 16'h0);
        chk(wreg, exp_w);
        $display("refusal test done");
    endtask : t_refuse
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_add();
        t_addc();
        t_and();
        t_refuse();
        t_reset();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        $display("[ERR] %0t run exceeded its cycle budget", $time);
        test_done();
    end
endmodule : aco_alu_core_bench

// *** core/aco_add8.sv ***
// 8-bit adder with carry in, carry, digit carry and signed overflow
// assumes purely combinational use inside the process phase
`timescale 1ns/1ns
module aco_add8 (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] sum,
    output logic cout,
    output logic half_cout,
    output logic ovf
);
    // ------------------------------------------------------------
    // sums
    // ------------------------------------------------------------
    wire [4:0] low_sum;                        // low nibble with carry out
    wire [8:0] full_sum;                       // full byte with carry out
    assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    assign full_sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign sum = full_sum[7:0];
    assign cout = full_sum[8];
    assign half_cout = low_sum[4];
    // overflow: like signs in, other sign out
    assign ovf = (a[7] == b[7]) && (full_sum[7] != a[7]);
endmodule : aco_add8

// *** core/aco_alu_core.sv ***
// four-phase execution of add with carry, add, and-literal and and-file
// assumes data memory answers a read within the same cycle as its strobe
// and that the bank select register is held by another block
`timescale 1ns/1ns
module aco_alu_core (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic [aco_pkg::BANK_W-1:0] bank_select_register,
    input wire logic [7:0] mem_rd_data,
    output logic instr_ready,
    output logic instr_unknown,
    output logic instr_done,
    output logic mem_rd_en,
    output logic mem_wr_en,
    output logic [aco_pkg::ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wr_data,
    output logic [7:0] wreg,
    output logic [7:0] status
);
    import aco_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    aco_phase_t phase_r;                       // current phase, one-hot
    aco_phase_t phase_nxt;
    aco_op_t op_r;                             // operation held from decode
    logic dest_file_r;                         // write result to the file byte
    logic [ADDR_W-1:0] addr_r;                 // resolved operand address
    logic [7:0] opnd_r;                        // literal or file operand
    logic [7:0] result_r;                      // processed result
    logic [7:0] stat_pend_r;                   // flags waiting for the write phase
    logic [7:0] wreg_r;                        // working register
    logic [7:0] status_r;                      // status flags

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire is_add_carry = (instr[15:10] == OPC_ADD_CARRY);  // [RL1]
    wire is_add_file = (instr[15:10] == OPC_ADD_FILE);    // [RL12]
    wire is_and_file = (instr[15:10] == OPC_AND_FILE);    // [RL8]
    wire is_and_lit = (instr[15:8] == OPC_AND_LIT);       // [RL6]
    wire is_known = is_add_carry | is_add_file | is_and_file | is_and_lit;
    wire take = (phase_r == PH_Q1) && instr_valid && is_known;
    wire [7:0] file_field = instr[7:0];
    wire use_bank_reg = instr[BANK_BIT];
    // literal form never touches memory, so its destination is forced to wreg
    wire dest_nxt = instr[DEST_BIT] & ~is_and_lit;
    aco_op_t op_dec;
    assign op_dec = is_add_carry ? OP_ADDC :
                    is_add_file ? OP_ADD :
                    is_and_file ? OP_ANDF : OP_ANDL;

    // ------------------------------------------------------------
    // address resolution
    // ------------------------------------------------------------
    // access bank maps the low half to bank zero and the high half to the top bank
    wire [BANK_W-1:0] access_bank = (file_field >= ACCESS_SPLIT) ? ACCESS_HI_BANK :
                                    ACCESS_LO_BANK;     // [RL4]
    wire [BANK_W-1:0] bank_nxt = use_bank_reg ? bank_select_register : access_bank; // [RL5]
    wire [ADDR_W-1:0] addr_nxt = {bank_nxt, file_field};

    // ------------------------------------------------------------
    // arithmetic and logic
    // ------------------------------------------------------------
    wire is_file_op = (op_r != OP_ANDL);
    wire is_add_op = (op_r == OP_ADDC) || (op_r == OP_ADD);
    // only the carry form feeds the carry flag back in
    wire carry_in = (op_r == OP_ADDC) & status_r[ST_C];          // [RL1] [RL12]
    logic [7:0] add_sum;
    logic add_c;
    logic add_hc;
    logic add_ovf;
    aco_add8 u_add (
        .a(wreg_r),
        .b(opnd_r),
        .cin(carry_in),
        .sum(add_sum),
        .cout(add_c),
        .half_cout(add_hc),
        .ovf(add_ovf)
    );
    wire [7:0] and_res = wreg_r & opnd_r;                        // [RL6] [RL8]
    wire [7:0] res_nxt = is_add_op ? add_sum : and_res;
    // and forms leave carry, digit carry and overflow as they were
    logic [7:0] stat_nxt;
    always_comb begin
        stat_nxt = status_r;
        stat_nxt[ST_N] = res_nxt[7];
        stat_nxt[ST_Z] = (res_nxt == 8'h00);
        if (is_add_op) begin                                     // [RL1] [RL12]
            stat_nxt[ST_C] = add_c;
            stat_nxt[ST_DCY] = add_hc;
            stat_nxt[ST_OVF] = add_ovf;
        end                                                      // [RL7] [RL8]
    end

    // ------------------------------------------------------------
    // phase sequencing
    // ------------------------------------------------------------
    // wait in decode until an accepted word arrives, then run three more phases
    always_comb begin
        case (phase_r)
            PH_Q1: phase_nxt = take ? PH_Q2 : PH_Q1;             // [RL11]
            PH_Q2: phase_nxt = PH_Q3;
            PH_Q3: phase_nxt = PH_Q4;
            PH_Q4: phase_nxt = PH_Q1;
            default: phase_nxt = PH_Q1;
        endcase
    end

    // phase register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_r <= PH_Q1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // decode captures: operation, destination, address
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            op_r <= OP_ANDL;
            dest_file_r <= 1'b0;
            addr_r <= '0;
        end else if (take) begin
            op_r <= op_dec;
            dest_file_r <= dest_nxt;
            addr_r <= addr_nxt;
        end
    end

    // operand: literal at decode, file byte at the end of the read phase
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            opnd_r <= 8'h00;
        end else if (take) begin
            opnd_r <= instr[7:0];
        end else if ((phase_r == PH_Q2) && is_file_op) begin
            opnd_r <= mem_rd_data;
        end
    end

    // process phase result and pending flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_r <= 8'h00;
            stat_pend_r <= STATUS_RST;
        end else if (phase_r == PH_Q3) begin
            result_r <= res_nxt;
            stat_pend_r <= stat_nxt;
        end
    end

    // write phase: wreg when destination is zero, flags always
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wreg_r <= WREG_RST;
            status_r <= STATUS_RST;
        end else if (phase_r == PH_Q4) begin
            if (!dest_file_r) begin
                wreg_r <= result_r;                              // [RL2]
            end
            status_r <= stat_pend_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign instr_ready = (phase_r == PH_Q1);
    // unsupported words are refused and the core stays in decode
    assign instr_unknown = (phase_r == PH_Q1) && instr_valid && !is_known;
    assign instr_done = (phase_r == PH_Q4);
    assign mem_rd_en = (phase_r == PH_Q2) && is_file_op;
    // memory write only for destination one; wreg is left alone then
    assign mem_wr_en = (phase_r == PH_Q4) && dest_file_r;         // [RL3]
    assign mem_addr = addr_r;
    assign mem_wr_data = result_r;
    assign wreg = wreg_r;
    assign status = status_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_addc_sum: assert property ((phase_r == PH_Q4) && (op_r == OP_ADDC) |-> // [RL1]
        result_r == 8'(wreg_r + opnd_r + {7'h00, status_r[ST_C]}))
        else $error("add with carry result wrong");
    a_add_plain: assert property ((phase_r == PH_Q4) && (op_r == OP_ADD) |-> // [RL12]
        result_r == 8'(wreg_r + opnd_r))
        else $error("plain add result wrong");
    a_dest_wreg: assert property ((phase_r == PH_Q4) && !dest_file_r |-> // [RL2]
        !mem_wr_en ##1 wreg_r == $past(result_r))
        else $error("wreg destination not honoured");
    a_dest_file: assert property (mem_wr_en |-> // [RL3]
        mem_wr_data == result_r ##1 $stable(wreg_r))
        else $error("file destination not honoured");
    a_bank_access: assert property (take && !use_bank_reg |=> // [RL4]
        mem_addr[ADDR_W-1:8] == ((mem_addr[7] == 1'b1) ? ACCESS_HI_BANK : ACCESS_LO_BANK))
        else $error("access bank address wrong");
    a_bank_reg: assert property (take && use_bank_reg |=> // [RL5]
        mem_addr == {$past(bank_select_register), $past(file_field)})
        else $error("banked address wrong");
    a_and_lit: assert property (take && is_and_lit |=> // [RL6]
        ##2 (!mem_wr_en && !mem_rd_en) ##1 wreg_r == ($past(wreg_r) & $past(opnd_r)))
        else $error("literal and result wrong");
    a_lit_flags: assert property ((phase_r == PH_Q4) && (op_r == OP_ANDL) |=> // [RL7]
        status_r[ST_C] == $past(status_r[ST_C]) && status_r[ST_OVF] == $past(status_r[ST_OVF])
        && status_r[ST_DCY] == $past(status_r[ST_DCY]))
        else $error("literal and touched arithmetic flags");
    a_andf_flags: assert property ((phase_r == PH_Q4) && (op_r == OP_ANDF) |-> // [RL8]
        result_r == (wreg_r & opnd_r) ##1
        status_r[ST_Z] == ($past(result_r) == 8'h00) && $stable(status_r[ST_C]))
        else $error("file and result or flags wrong");
    a_phase_walk: assert property (take |=> // [RL11]
        (phase_r == PH_Q2) ##1 (phase_r == PH_Q3) ##1 (phase_r == PH_Q4) ##1
        (phase_r == PH_Q1))
        else $error("phase sequence broken");
endmodule : aco_alu_core

// *** core/aco_pkg.sv ***
// constants, encodings and types for the add/and execution datapath
// assumes a single instruction clock and a data memory owned by another block
//
// Notes on behaviour
// RL1: add-with-carry sums wreg, operand, carry; five flags
// RL2: destination bit zero writes wreg only
// RL3: destination bit one writes the file byte
// RL4: bank bit zero resolves within access bank
// RL5: bank bit one uses bank select register
// RL6: literal and writes wreg and literal into wreg
// RL7: literal and updates negative and zero only
// RL8: file and ands operand; negative, zero only
// RL9: assembler default destination for file and is one
// RL10: assembler default bank bit for file and is one
// RL11: one word, four phases: decode, read, process, write
// RL12: plain add has no carry in; five flags
package aco_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int BANK_W = 4;                 // bank select register width
    localparam int ADDR_W = BANK_W + 8;        // bank plus 8-bit file field
    // ------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------
    localparam logic [5:0] OPC_ADD_CARRY = 6'h08; // 0010 00da
    localparam logic [5:0] OPC_ADD_FILE = 6'h09;  // 0010 01da
    localparam logic [5:0] OPC_AND_FILE = 6'h05;  // 0001 01da
    localparam logic [7:0] OPC_AND_LIT = 8'h0b;   // 0000 1011
    localparam int DEST_BIT = 9;               // position of destination bit
    localparam int BANK_BIT = 8;               // position of bank bit
    // ------------------------------------------------------------
    // access bank split: low half in bank zero, high half in top bank
    // ------------------------------------------------------------
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;
    // ------------------------------------------------------------
    // status bit positions and reset values
    // ------------------------------------------------------------
    localparam int ST_C = 0;                   // carry
    localparam int ST_DCY = 1;                 // digit carry
    localparam int ST_Z = 2;                   // zero
    localparam int ST_OVF = 3;                 // overflow
    localparam int ST_N = 4;                   // negative
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] WREG_RST = 8'h00;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_Q1 = 4'h1,                          // decode
        PH_Q2 = 4'h2,                          // operand read
        PH_Q3 = 4'h4,                          // process
        PH_Q4 = 4'h8                           // write
    } aco_phase_t;
    typedef enum logic [1:0] {
        OP_ADDC = 2'h0,                        // add_wreg_file_with_carry
        OP_ADD = 2'h1,                         // add_wreg_to_file
        OP_ANDF = 2'h2,                        // and_wreg_with_file
        OP_ANDL = 2'h3                         // and_literal_into_wreg
    } aco_op_t;
endpackage : aco_pkg
